// [design/lata_emul.v]
// Legacy taskfile emulation with master/slave pairing and interrupt state machines.
// What this block does
// - Two shadow sets, chosen by drive select.
// - Command and control accesses go to selected set.
// - Missing second drive: act as lone first.
// - Soft reset set: update and frame all present.
// - Soft reset clear: frame all present drives.
// - After soft reset await replies, merge results.
// - Diagnostic command: update and frame all present.
// - After diagnostics await replies, merge results.
// - Serial-only superset features are not supported.
// - Pairing enabled only by software choice.
// - Keep an interrupt pending flag per drive.
// - Interrupt low when idle, high in irq.
// - Link reset request keeps idle state.
// - Control write, no interrupt condition: stay idle.
// - Control write with pending, enabled: raise interrupt.
// - Control write with soft reset: stay idle.
// - Command write keeps idle state.
// - Drive select write to other: deselected.
// - Other accesses leave idle state unchanged.
// - Update without enabled pending flag: stay idle.
// - Update setting flag, interrupts enabled: raise.
// - Clear flag on reset, control write, status read.
// - Command or soft reset change sets busy.
`timescale 1ns/1ps
`include "lata_defines.vh"

module lata_emul #(
    parameter TMO_CYCLES = `LATA_TMO_US * `LATA_CLK_MHZ
) (
    // Clock and reset.
    input wire I_CLK,
    input wire I_RESET_N,
    // Avalon-MM register slave.
    input wire [7:0] I_AVS_ADDRESS,
    input wire I_AVS_READ,
    input wire I_AVS_WRITE,
    input wire [3:0] I_AVS_BYTEENABLE,
    input wire [31:0] I_AVS_WRITEDATA,
    output wire [31:0] O_AVS_READDATA,
    output wire O_AVS_WAITREQUEST,
    // Drive presence and register updates from the transport layer.
    input wire [1:0] I_PHY_PRESENT,
    input wire [1:0] I_RX_VALID,
    input wire [1:0] I_RX_IRQ,
    input wire [15:0] I_RX_STATUS,
    input wire [15:0] I_RX_ERROR,
    // Register frame and link reset requests toward the transport layer.
    output wire [1:0] O_FIS_REQ,
    output wire O_FIS_IS_CMD,
    output wire [15:0] O_FIS_COMMAND,
    output wire [7:0] O_FIS_DEVCTL,
    output wire [7:0] O_FIS_DEVHEAD,
    output wire O_COMRESET_REQ,
    // Host interrupt.
    output wire O_INTRQ
);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function sel_fn;
        input integer p;
        input drv;
        input pair1;
        begin
            sel_fn = (p == 0) ? ~drv : (drv & pair1);
        end
    endfunction

    function [3:0] tf_idx;
        input port;
        input [7:0] addr;
        begin
            tf_idx = (port ? 4'h5 : 4'h0) + addr[5:2] - 4'h1;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // State.

    reg ack_r;
    reg [31:0] rdata_r, rdata_nxt;
    reg [79:0] tf_r, tf_nxt;
    reg [15:0] stat_r, stat_nxt;
    reg [15:0] err_r, err_nxt;
    reg [15:0] cmd_r, cmd_nxt;
    reg [7:0] devhead_r, devhead_nxt;
    reg [7:0] devctl_r, devctl_nxt;
    reg [1:0] ipf_r, ipf_nxt;
    reg [3:0] st_r, st_nxt;
    reg ms_en_r, ms_en_nxt;
    reg [1:0] fis_req_r, fis_req_nxt;
    reg fis_cmd_r, fis_cmd_nxt;
    reg comreset_r, comreset_nxt;
    reg merge_r, merge_nxt;
    reg [1:0] resp_r, resp_nxt;
    reg [1:0] mask_r, mask_nxt;
    reg [31:0] tmo_r, tmo_nxt;

    wire acc = (I_AVS_READ | I_AVS_WRITE) & ack_r;
    wire acc_wr = I_AVS_WRITE & ack_r;
    wire acc_rd = I_AVS_READ & ack_r;
    wire be0 = I_AVS_BYTEENABLE[0];
    wire [7:0] wd = I_AVS_WRITEDATA[7:0];
    wire pair1 = ms_en_r & I_PHY_PRESENT[1];
    wire [1:0] pair_mask = {pair1, I_PHY_PRESENT[0]};
    wire drv = devhead_r[`LATA_DEVHEAD_DRV_SEL];
    wire tgt = drv & pair1;
    wire ghost = drv & ~pair1;
    wire is_tf = (I_AVS_ADDRESS >= `LATA_OFF_ERR) && (I_AVS_ADDRESS <= `LATA_OFF_LBAH);
    wire wr_devhead = acc_wr && be0 && (I_AVS_ADDRESS == `LATA_OFF_DEVHEAD);
    wire wr_cmd = acc_wr && be0 && (I_AVS_ADDRESS == `LATA_OFF_STATUS) && !ghost;
    wire wr_ctrl = acc_wr && be0 && (I_AVS_ADDRESS == `LATA_OFF_CTRL);
    wire rd_stat = acc_rd && (I_AVS_ADDRESS == `LATA_OFF_STATUS);
    wire wr_cfg = acc_wr && be0 && (I_AVS_ADDRESS == `LATA_OFF_CFG);
    wire comreset = wr_cfg && wd[`LATA_CFG_COMRESET];
    wire soft_new = wd[`LATA_DEVCTL_SOFT_RST];
    wire soft_chg = soft_new ^ devctl_r[`LATA_DEVCTL_SOFT_RST];
    wire int_dis = devctl_r[`LATA_DEVCTL_INT_DIS];
    wire [1:0] resp_all = resp_r | ~mask_r;
    wire merge_done = (resp_all == 2'h3) || (tmo_r >= TMO_CYCLES - 1);
    wire d1_fail = mask_r[1] & resp_r[1] & (err_r[15:8] != `LATA_DIAG_PASS);
    wire [7:0] d0_err = resp_r[0] ? err_r[7:0] : 8'h00;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Avalon answer: one wait state, read data from a flop.

    assign O_AVS_WAITREQUEST = (I_AVS_READ | I_AVS_WRITE) & ~ack_r;
    assign O_AVS_READDATA = rdata_r;

    always @*
    begin
        rdata_nxt = 32'h00000000;
        if (is_tf)
        begin
            if (ghost)
                rdata_nxt = 32'h00000000;
            else if (I_AVS_ADDRESS == `LATA_OFF_ERR)
                rdata_nxt[7:0] = err_r[tgt*8 +: 8];
            else
                rdata_nxt[7:0] = tf_r[tf_idx(tgt, I_AVS_ADDRESS)*8 +: 8];
        end
        else if (I_AVS_ADDRESS == `LATA_OFF_DEVHEAD)
            rdata_nxt[7:0] = devhead_r;
        else if ((I_AVS_ADDRESS == `LATA_OFF_STATUS) || (I_AVS_ADDRESS == `LATA_OFF_CTRL))
        begin
            if (!ghost)
            begin
                rdata_nxt[7:0] = stat_r[tgt*8 +: 8];
                if (merge_r)
                    rdata_nxt[`LATA_STATUS_BUSY] = 1'b1;
            end
        end
        else if (I_AVS_ADDRESS == `LATA_OFF_CFG)
            rdata_nxt[`LATA_CFG_MS_EN] = ms_en_r;
        else if (I_AVS_ADDRESS == `LATA_OFF_INFO)
            rdata_nxt[12:0] = {merge_r, st_r, ipf_r, pair_mask, I_PHY_PRESENT, resp_r};
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Shadow registers, frame requests, merge and interrupt state.

    integer p;

    always @*
    begin
        tf_nxt = tf_r;
        stat_nxt = stat_r;
        err_nxt = err_r;
        cmd_nxt = cmd_r;
        devhead_nxt = devhead_r;
        devctl_nxt = devctl_r;
        ipf_nxt = ipf_r;
        st_nxt = st_r;
        ms_en_nxt = ms_en_r;
        fis_req_nxt = 2'h0;
        fis_cmd_nxt = fis_cmd_r;
        comreset_nxt = comreset;
        merge_nxt = merge_r;
        resp_nxt = resp_r;
        mask_nxt = mask_r;
        tmo_nxt = tmo_r;

        // Drive register updates.
        for (p = 0; p < 2; p = p + 1)
        begin
            if (I_RX_VALID[p])
            begin
                stat_nxt[p*8 +: 8] = I_RX_STATUS[p*8 +: 8];
                err_nxt[p*8 +: 8] = I_RX_ERROR[p*8 +: 8];
                if (merge_r)
                    resp_nxt[p] = 1'b1;
            end
        end

        // Merge of the pair's diagnostic results.
        if (merge_r)
        begin
            tmo_nxt = tmo_r + 32'h00000001;
            if (merge_done)
            begin
                merge_nxt = 1'b0;
                err_nxt[7:0] = {d1_fail, d0_err[6:0]};
            end
        end

        // Host writes.
        if (acc_wr && be0)
        begin
            if (is_tf && !ghost)
                tf_nxt[tf_idx(tgt, I_AVS_ADDRESS)*8 +: 8] = wd;
            else if (is_tf)
                tf_nxt[tf_idx(1'b0, I_AVS_ADDRESS)*8 +: 8] = wd;
            else if (I_AVS_ADDRESS == `LATA_OFF_DEVHEAD)
                devhead_nxt = wd;
            else if (wr_cmd)
            begin
                fis_cmd_nxt = 1'b1;
                if (ms_en_r && (wd == `LATA_CMD_DIAG))
                begin
                    for (p = 0; p < 2; p = p + 1)
                    begin
                        if (pair_mask[p])
                        begin
                            cmd_nxt[p*8 +: 8] = wd;
                            stat_nxt[p*8 + `LATA_STATUS_BUSY] = 1'b1;
                            fis_req_nxt[p] = 1'b1;
                        end
                    end
                    merge_nxt = 1'b1;
                    resp_nxt = 2'h0;
                    mask_nxt = pair_mask;
                    tmo_nxt = 32'h00000000;
                end
                else
                begin
                    cmd_nxt[tgt*8 +: 8] = wd;
                    stat_nxt[tgt*8 + `LATA_STATUS_BUSY] = 1'b1;
                    fis_req_nxt[tgt] = 1'b1;
                end
            end
            else if (wr_ctrl)
            begin
                devctl_nxt = wd;
                fis_cmd_nxt = 1'b0;
                if (soft_chg || soft_new)
                begin
                    for (p = 0; p < 2; p = p + 1)
                    begin
                        if (pair_mask[p])
                        begin
                            fis_req_nxt[p] = 1'b1;
                            if (soft_chg)
                                stat_nxt[p*8 + `LATA_STATUS_BUSY] = 1'b1;
                        end
                    end
                    if (ms_en_r && soft_chg && !soft_new)
                    begin
                        merge_nxt = 1'b1;
                        resp_nxt = 2'h0;
                        mask_nxt = pair_mask;
                        tmo_nxt = 32'h00000000;
                    end
                end
                else if (!ghost)
                    fis_req_nxt[tgt] = 1'b1;
            end
            else if (wr_cfg)
                ms_en_nxt = wd[`LATA_CFG_MS_EN];
        end
        if (comreset)
            stat_nxt = {stat_r[15] | pair_mask[1], stat_r[14:8], stat_r[7] | pair_mask[0], stat_r[6:0]};

        // Interrupt pending flags and per-drive interrupt state.
        for (p = 0; p < 2; p = p + 1)
        begin
            if (comreset || ((wr_ctrl || rd_stat) && sel_fn(p, drv, pair1)))
                ipf_nxt[p] = 1'b0;
            if (I_RX_VALID[p] && I_RX_IRQ[p])
                ipf_nxt[p] = 1'b1;
            case (st_r[p*2 +: 2])
                `LATA_ST_IDLE:
                begin
                    if (wr_devhead && !sel_fn(p, wd[`LATA_DEVHEAD_DRV_SEL], pair1))
                        st_nxt[p*2 +: 2] = `LATA_ST_DESEL;
                    else if (wr_ctrl && !soft_new && !wd[`LATA_DEVCTL_INT_DIS] && ipf_r[p])
                        st_nxt[p*2 +: 2] = `LATA_ST_IRQ;
                    else if (I_RX_VALID[p] && I_RX_IRQ[p] && !int_dis && !comreset && !wr_ctrl)
                        st_nxt[p*2 +: 2] = `LATA_ST_IRQ;
                    else
                        st_nxt[p*2 +: 2] = `LATA_ST_IDLE;
                end
                `LATA_ST_IRQ:
                begin
                    if (wr_devhead && !sel_fn(p, wd[`LATA_DEVHEAD_DRV_SEL], pair1))
                        st_nxt[p*2 +: 2] = `LATA_ST_DESEL;
                    else if (comreset || wr_ctrl || wr_cmd || rd_stat)
                        st_nxt[p*2 +: 2] = `LATA_ST_IDLE;
                    else
                        st_nxt[p*2 +: 2] = `LATA_ST_IRQ;
                end
                `LATA_ST_DESEL:
                begin
                    if (wr_devhead && sel_fn(p, wd[`LATA_DEVHEAD_DRV_SEL], pair1))
                        st_nxt[p*2 +: 2] = (ipf_nxt[p] && !int_dis) ? `LATA_ST_IRQ : `LATA_ST_IDLE;
                    else
                        st_nxt[p*2 +: 2] = `LATA_ST_DESEL;
                end
                default:
                    st_nxt[p*2 +: 2] = `LATA_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Flops.

    always @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
            tf_r <= {10{`LATA_RST_TF}};
            stat_r <= {2{`LATA_RST_STATUS}};
            err_r <= {2{`LATA_RST_TF}};
            cmd_r <= {2{`LATA_RST_TF}};
            devhead_r <= `LATA_RST_TF;
            devctl_r <= `LATA_RST_DEVCTL;
            ipf_r <= 2'h0;
            st_r <= {`LATA_ST_DESEL, `LATA_ST_IDLE};
            ms_en_r <= 1'b0;
            fis_req_r <= 2'h0;
            fis_cmd_r <= 1'b0;
            comreset_r <= 1'b0;
            merge_r <= 1'b0;
            resp_r <= 2'h0;
            mask_r <= 2'h0;
            tmo_r <= 32'h00000000;
        end
        else
        begin
            ack_r <= (I_AVS_READ | I_AVS_WRITE) & ~ack_r & ~acc;
            if (I_AVS_READ && !ack_r)
                rdata_r <= rdata_nxt;
            tf_r <= tf_nxt;
            stat_r <= stat_nxt;
            err_r <= err_nxt;
            cmd_r <= cmd_nxt;
            devhead_r <= devhead_nxt;
            devctl_r <= devctl_nxt;
            ipf_r <= ipf_nxt;
            st_r <= st_nxt;
            ms_en_r <= ms_en_nxt;
            fis_req_r <= fis_req_nxt;
            fis_cmd_r <= fis_cmd_nxt;
            comreset_r <= comreset_nxt;
            merge_r <= merge_nxt;
            resp_r <= resp_nxt;
            mask_r <= mask_nxt;
            tmo_r <= tmo_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign O_FIS_REQ = fis_req_r;
    assign O_FIS_IS_CMD = fis_cmd_r;
    assign O_FIS_COMMAND = cmd_r;
    assign O_FIS_DEVCTL = devctl_r;
    assign O_FIS_DEVHEAD = devhead_r;
    assign O_COMRESET_REQ = comreset_r;
    assign O_INTRQ = (st_r[1:0] == `LATA_ST_IRQ) || (st_r[3:2] == `LATA_ST_IRQ);

endmodule // lata_emul

// [shared/lata_defines.vh]
// Offsets, field positions, reset values and timing figures of the legacy taskfile emulation block.
`ifndef LATA_DEFINES_VH
`define LATA_DEFINES_VH
`define LATA_OFF_ERR 8'h04
`define LATA_OFF_SECCNT 8'h08
`define LATA_OFF_LBAL 8'h0c
`define LATA_OFF_LBAM 8'h10
`define LATA_OFF_LBAH 8'h14
`define LATA_OFF_DEVHEAD 8'h18
`define LATA_OFF_STATUS 8'h1c
`define LATA_OFF_CTRL 8'h20
`define LATA_OFF_CFG 8'h24
`define LATA_OFF_INFO 8'h28
`define LATA_RST_STATUS 8'h7f
`define LATA_RST_TF 8'hff
`define LATA_RST_DEVCTL 8'h00
`define LATA_DEVHEAD_DRV_SEL 4
`define LATA_DEVCTL_SOFT_RST 2
`define LATA_DEVCTL_INT_DIS 1
`define LATA_STATUS_BUSY 7
`define LATA_CFG_MS_EN 0
`define LATA_CFG_COMRESET 1
`define LATA_CMD_DIAG 8'h90
`define LATA_DIAG_PASS 8'h01
`define LATA_TMO_US 100000
`define LATA_CLK_MHZ 200
`define LATA_ST_IDLE 2'h0
`define LATA_ST_IRQ 2'h1
`define LATA_ST_DESEL 2'h2
`endif

// [test/lata_emul_monitor.sv]
// Assertion checker for the legacy taskfile emulation ports.
`timescale 1ns/1ps
`include "lata_defines.vh"
module lata_emul_monitor (
    // Clock, reset and register bus.
    input wire I_CLK,
    input wire I_RESET_N,
    input wire [7:0] I_AVS_ADDRESS,
    input wire I_AVS_READ,
    input wire I_AVS_WRITE,
    input wire [3:0] I_AVS_BYTEENABLE,
    input wire [31:0] I_AVS_WRITEDATA,
    input wire O_AVS_WAITREQUEST,
    // Drive side and interrupt.
    input wire [1:0] I_PHY_PRESENT,
    input wire [1:0] I_RX_VALID,
    input wire [1:0] I_RX_IRQ,
    input wire [1:0] O_FIS_REQ,
    input wire [7:0] O_FIS_DEVCTL,
    input wire [7:0] O_FIS_DEVHEAD,
    input wire O_COMRESET_REQ,
    input wire O_INTRQ
);
    wire rq = I_AVS_READ | I_AVS_WRITE;
    wire rxi = |(I_RX_VALID & I_RX_IRQ);
    wire acc = I_AVS_WRITE & ~O_AVS_WAITREQUEST;
    wire [7:0] wd = I_AVS_WRITEDATA[7:0];
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    ////////////////////////////////////////
    sequence s_wr(a);
        acc && I_AVS_BYTEENABLE[0] && I_AVS_ADDRESS == a;
    endsequence
    property p_wait;
        $rose(rq) |-> O_AVS_WAITREQUEST ##1 !O_AVS_WAITREQUEST;
    endproperty
    a_wait: assert property (p_wait)
        else $error("bus wait state count wrong");
    property p_src;
        $rose(O_INTRQ) |-> $past(acc) || $past(rxi);
    endproperty
    a_src: assert property (p_src)
        else $error("interrupt rose without cause");
    property p_rx_irq;
        I_RX_VALID[0] && I_RX_IRQ[0] && !O_FIS_DEVCTL[1] && !O_FIS_DEVHEAD[4] && !rq |=> O_INTRQ;
    endproperty
    a_rx_irq: assert property (p_rx_irq)
        else $error("update with flag did not raise interrupt");
    property p_rx_mask;
        (|I_RX_VALID) && (O_FIS_DEVCTL[1] || !rxi) && !O_INTRQ && !rq |=> !O_INTRQ;
    endproperty
    a_rx_mask: assert property (p_rx_mask)
        else $error("masked update raised interrupt");
    property p_desel;
        s_wr(`LATA_OFF_DEVHEAD) ##0 (wd[4] && !I_PHY_PRESENT[1]) |=> !O_INTRQ;
    endproperty
    a_desel: assert property (p_desel)
        else $error("interrupt high after deselect");
    property p_soft_reset_bit;
        s_wr(`LATA_OFF_CTRL) ##0 (wd[2] != O_FIS_DEVCTL[2] && I_PHY_PRESENT[0] && !O_FIS_DEVHEAD[4])
            |=> O_FIS_REQ[0] && O_FIS_DEVCTL == $past(wd);
    endproperty
    a_soft_reset_bit: assert property (p_soft_reset_bit)
        else $error("soft reset change sent no frame");
    property p_cmd;
        s_wr(`LATA_OFF_STATUS) ##0 (!O_FIS_DEVHEAD[4] && I_PHY_PRESENT[0] && !O_INTRQ && !rxi)
            |=> O_FIS_REQ[0] && !O_INTRQ;
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("command write mishandled");
    property p_crst;
        s_wr(`LATA_OFF_CFG) ##0 wd[1] |=> O_COMRESET_REQ && !O_INTRQ;
    endproperty
    a_crst: assert property (p_crst)
        else $error("link reset mishandled");
endmodule // lata_emul_monitor
bind lata_emul lata_emul_monitor u_mon (
    .I_CLK(I_CLK),
    .I_RESET_N(I_RESET_N),
    .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ),
    .I_AVS_WRITE(I_AVS_WRITE),
    .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE),
    .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .I_PHY_PRESENT(I_PHY_PRESENT),
    .I_RX_VALID(I_RX_VALID),
    .I_RX_IRQ(I_RX_IRQ),
    .O_FIS_REQ(O_FIS_REQ),
    .O_FIS_DEVCTL(O_FIS_DEVCTL),
    .O_FIS_DEVHEAD(O_FIS_DEVHEAD),
    .O_COMRESET_REQ(O_COMRESET_REQ),
    .O_INTRQ(O_INTRQ)
);

// [test/lata_drv_model.sv]
// Behavioural model of the two serial drives.
`timescale 1ns/1ps
module lata_drv_model #(
    parameter DLY = 12,
    parameter [7:0] ERR1 = 8'h02
) (
    // Clock, reset and controls.
    input wire i_clk,
    input wire i_rst_n,
    input wire [1:0] i_req,
    input wire [1:0] i_mute,
    input wire [1:0] i_kick,
    // Register frames back.
    output reg [1:0] o_vld,
    output reg [1:0] o_irq,
    output reg [15:0] o_st,
    output reg [15:0] o_er
);
    reg [7:0] c0_r;
    reg [7:0] c1_r;
    wire [1:0] v = i_kick | {c1_r == 8'h01 && !i_mute[1], c0_r == 8'h01 && !i_mute[0]};
    // Each drive counts on its own; a new frame restarts that drive's reply.
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            c0_r <= 8'h00;
            c1_r <= 8'h00;
            o_vld <= 2'h0;
            o_irq <= 2'h0;
            o_st <= 16'h0000;
            o_er <= 16'h0000;
        end
        else
        begin
            c0_r <= i_req[0] ? 8'(DLY) : c0_r - {7'h00, c0_r != 8'h00};
            c1_r <= i_req[1] ? 8'(DLY + 8) : c1_r - {7'h00, c1_r != 8'h00};
            o_vld <= v;
            o_irq <= i_kick;
            o_st <= (|v) ? 16'h5050 : ~o_st;
            o_er <= (|v) ? {ERR1, 8'h01} : ~o_er;
        end
    end
endmodule // lata_drv_model

// [test/lata_emul_bench.sv]
// Self-checking bench for the legacy taskfile emulation block.
`timescale 1ns/1ps
`include "lata_defines.vh"
module lata_emul_bench;
    logic clk = 0, rst_n = 0, rd = 0, wr = 0, waitreq, intrq, is_cmd;
    logic [7:0] addr = 8'h00, a, d;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [1:0] phy = 2'h1, mute = 2'h0, kick = 2'h0, vld, irq, req, seen;
    logic [15:0] st, er, cmd;
    integer fail_count = 0, comparisons = 0, cyc = 0;
    lata_emul #(.TMO_CYCLES(50)) dut (.I_CLK(clk), .I_RESET_N(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_BYTEENABLE(4'hf), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(waitreq), .I_PHY_PRESENT(phy), .I_RX_VALID(vld), .I_RX_IRQ(irq), .I_RX_STATUS(st),
        .I_RX_ERROR(er), .O_FIS_REQ(req), .O_FIS_IS_CMD(is_cmd), .O_FIS_COMMAND(cmd), .O_FIS_DEVCTL(),
        .O_FIS_DEVHEAD(), .O_COMRESET_REQ(), .O_INTRQ(intrq));
    lata_drv_model u_drv (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_mute(mute), .i_kick(kick),
        .o_vld(vld), .o_irq(irq), .o_st(st), .o_er(er));
    ////////////////////////////////////////
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    always @(negedge clk) seen <= seen | req;
    task close_out;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            close_out;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
    begin
        comparisons++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    end
    endtask
    task bus(input logic w, input [7:0] ad, input [7:0] dd);
    begin
        addr <= ad;
        wdata <= {24'h0, dd};
        wr <= w;
        rd <= !w;
        do
            @(posedge clk);
        while (waitreq);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    end
    endtask
    task put(input [7:0] ad, input [7:0] dd);
        bus(1'b1, ad, dd);
    endtask
    task rc(input [7:0] ad, input [7:0] e);
    begin
        bus(1'b0, ad, 8'h00);
        chk(q, {24'h0, e});
    end
    endtask
    task ci(input logic e);
    begin
        @(negedge clk);
        chk(intrq, e);
        @(posedge clk);
    end
    endtask
    task kk(input [1:0] k);
    begin
        kick <= k;
        @(posedge clk);
        kick <= 2'h0;
        repeat (3) @(posedge clk);
    end
    endtask
    task mw;
        integer n;
    begin
        n = 0;
        do
        begin
            bus(1'b0, `LATA_OFF_INFO, 8'h00);
            n++;
        end
        while (q[12] && n < 60);
        chk(q[12], 1'b0);
    end
    endtask
    function automatic [7:0] merged_err(input logic r0, input logic r1, input [7:0] e0, input [7:0] e1);
        merged_err = {r1 && (e1 != `LATA_DIAG_PASS), r0 ? e0[6:0] : 7'h00};
    endfunction
    ////////////////////////////////////////
    initial
    begin
        q = $urandom(32'h920548cf);
        seen = 2'h0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        put(`LATA_OFF_DEVHEAD, 8'h00);
        rc(`LATA_OFF_LBAL, `LATA_RST_TF);
        rc(8'h3c, 8'h00);
        repeat (8)
        begin
            a = 8'h08 + 8'(4 * ($urandom % 4));
            d = 8'($urandom);
            put(a, d);
            rc(a, d);
        end
        ci(1'b0);
        put(`LATA_OFF_CTRL, 8'h00);
        ci(1'b0);
        kk(2'h1);
        ci(1'b1);
        bus(1'b0, `LATA_OFF_STATUS, 8'h00);
        ci(1'b0);
        put(`LATA_OFF_CTRL, 8'h02);
        kk(2'h1);
        ci(1'b0);
        bus(1'b0, `LATA_OFF_INFO, 8'h00);
        chk(q[7:6], 2'h1);
        put(`LATA_OFF_CTRL, 8'h00);
        ci(1'b1);
        bus(1'b0, `LATA_OFF_STATUS, 8'h00);
        put(`LATA_OFF_CTRL, 8'h04);
        ci(1'b0);
        bus(1'b0, `LATA_OFF_STATUS, 8'h00);
        chk(q[7], 1'b1);
        put(`LATA_OFF_CTRL, 8'h00);
        repeat (30) @(posedge clk);
        put(`LATA_OFF_CTRL, 8'h02);
        kk(2'h1);
        put(`LATA_OFF_CFG, 8'h02);
        bus(1'b0, `LATA_OFF_INFO, 8'h00);
        chk(q[7:6], 2'h0);
        ci(1'b0);
        put(`LATA_OFF_CTRL, 8'h00);
        put(`LATA_OFF_STATUS, 8'hec);
        ci(1'b0);
        chk(cmd[7:0], 8'hec);
        chk(is_cmd, 1'b1);
        put(`LATA_OFF_DEVHEAD, 8'h10);
        bus(1'b0, `LATA_OFF_INFO, 8'h00);
        chk(q[9:8], `LATA_ST_DESEL);
        kk(2'h1);
        ci(1'b0);
        put(`LATA_OFF_DEVHEAD, 8'h00);
        bus(1'b0, `LATA_OFF_STATUS, 8'h00);
        put(`LATA_OFF_CFG, 8'h01);
        put(`LATA_OFF_DEVHEAD, 8'h10);
        put(`LATA_OFF_STATUS, 8'h20);
        ci(1'b0);
        chk(cmd[7:0], 8'hec);
        phy <= 2'h3;
        put(`LATA_OFF_DEVHEAD, 8'h00);
        put(`LATA_OFF_LBAL, 8'h11);
        put(`LATA_OFF_DEVHEAD, 8'h10);
        put(`LATA_OFF_LBAL, 8'h22);
        rc(`LATA_OFF_LBAL, 8'h22);
        put(`LATA_OFF_DEVHEAD, 8'h00);
        rc(`LATA_OFF_LBAL, 8'h11);
        seen = 2'h0;
        put(`LATA_OFF_STATUS, `LATA_CMD_DIAG);
        mw;
        chk(seen, 2'h3);
        chk(cmd, {2{`LATA_CMD_DIAG}});
        rc(`LATA_OFF_ERR, merged_err(1'b1, 1'b1, 8'h01, 8'h02));
        mute <= 2'h2;
        put(`LATA_OFF_STATUS, `LATA_CMD_DIAG);
        mw;
        rc(`LATA_OFF_ERR, merged_err(1'b1, 1'b0, 8'h01, 8'h02));
        mute <= 2'h0;
        seen = 2'h0;
        put(`LATA_OFF_CTRL, 8'h04);
        chk(seen, 2'h3);
        seen = 2'h0;
        put(`LATA_OFF_CTRL, 8'h00);
        mw;
        chk(seen, 2'h3);
        rc(`LATA_OFF_ERR, merged_err(1'b1, 1'b1, 8'h01, 8'h02));
        close_out;
    end
endmodule // lata_emul_bench
